//--- rtl/gpio_efg_pkg.sv
// shared constants and carrier types for the port e/f/g block
package gpio_efg_pkg;
   localparam logic [7:0] port_e_data_offset = 8'h08;
   localparam logic [7:0] port_f_data_offset = 8'h09;
   localparam logic [7:0] port_g_data_offset = 8'h0a;
   localparam logic [7:0] port_e_dir_offset = 8'h0c;
   localparam logic [7:0] port_f_dir_offset = 8'h0d;
   localparam logic [7:0] port_g_dir_offset = 8'h0e;
   localparam int port_e_width = 8;
   localparam int port_f_width = 5;
   localparam int port_g_width = 3;
   localparam int timer_pins = 4;
   localparam logic [7:0] dir_reset_value = 8'h00;
   localparam logic [1:0] els_gpio = 2'h0;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_type;

   typedef struct packed {
      logic [7:0] value;
      logic [7:0] oe;
   } pin_drive_type;
endpackage : gpio_efg_pkg

//--- rtl/pin_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(parameter int width = 8)
(
   input wire logic sys_clk,
   input wire logic [width-1:0] async_in,
   output logic [width-1:0] sync_out
);
   logic [width-1:0] stage1;
   logic [width-1:0] stage2;

   // no reset: pin levels carry no control state
   always_ff @(posedge sys_clk)
   begin
      stage1 <= async_in;
      stage2 <= stage1;
   end

   assign sync_out = stage2;
endmodule : pin_sync

//--- rtl/port_bit.sv
// one gpio pin slice: output drive choice and read-back mux
`timescale 1ns/1ps
module port_bit
(
   input wire logic latch,
   input wire logic dir,
   input wire logic pin_level,
   input wire logic periph_owns,
   input wire logic periph_out,
   input wire logic periph_oe,
   output logic read_value,
   output logic drive_value,
   output logic drive_oe
);
   // direction picks latch or pin even when a peripheral owns the pin
   assign read_value = dir ? latch : pin_level;
   assign drive_value = periph_owns ? periph_out : latch;
   assign drive_oe = periph_owns ? periph_oe : dir;
endmodule : port_bit

//--- rtl/gpio_ports_e_f_g.sv
// gpio logic for ports e, f and g with register port
`timescale 1ns/1ps
module gpio_ports_e_f_g
   import gpio_efg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic [port_e_width-1:0] port_e_in,
   output logic [port_e_width-1:0] port_e_out,
   output logic [port_e_width-1:0] port_e_oe,
   input wire logic [port_e_width-1:0] port_e_periph_owns,
   input wire logic [port_e_width-1:0] port_e_periph_out,
   input wire logic [port_e_width-1:0] port_e_periph_oe,
   input wire logic [port_f_width-1:0] port_f_in,
   output logic [port_f_width-1:0] port_f_out,
   output logic [port_f_width-1:0] port_f_oe,
   input wire logic [2*timer_pins-1:0] edge_level_select,
   input wire logic [timer_pins-1:0] capture_compare_out,
   input wire logic [timer_pins-1:0] capture_compare_oe,
   output logic [timer_pins-1:0] capture_compare_pins,
   input wire logic [port_g_width-1:0] port_g_in,
   output logic [port_g_width-1:0] port_g_out,
   output logic [port_g_width-1:0] port_g_oe
);
   bus_req_type req;
   logic [port_e_width-1:0] port_e_latches;
   logic [port_e_width-1:0] next_port_e_latches;
   logic [port_e_width-1:0] port_e_direction;
   logic [port_e_width-1:0] next_port_e_direction;
   logic [port_f_width-1:0] port_f_pin_data;
   logic [port_f_width-1:0] next_port_f_pin_data;
   logic [port_f_width-1:0] port_f_direction;
   logic [port_f_width-1:0] next_port_f_direction;
   logic [port_g_width-1:0] port_g_pin_data;
   logic [port_g_width-1:0] next_port_g_pin_data;
   logic [port_g_width-1:0] port_g_direction;
   logic [port_g_width-1:0] next_port_g_direction;
   logic [7:0] next_rdata;
   logic [port_e_width-1:0] e_sync;
   logic [port_f_width-1:0] f_sync;
   logic [port_g_width-1:0] g_sync;
   logic [port_e_width-1:0] e_read;
   logic [port_e_width-1:0] e_val;
   logic [port_e_width-1:0] e_en;
   logic [port_f_width-1:0] f_read;
   logic [port_f_width-1:0] f_val;
   logic [port_f_width-1:0] f_en;
   logic [port_g_width-1:0] g_read;
   logic [port_g_width-1:0] g_val;
   logic [port_g_width-1:0] g_en;
   logic [port_f_width-1:0] f_owns;
   logic [port_f_width-1:0] f_pout;
   logic [port_f_width-1:0] f_poe;
   pin_drive_type e_drive;
   pin_drive_type next_e_drive;
   logic [port_f_width-1:0] next_port_f_out;
   logic [port_f_width-1:0] next_port_f_oe;
   logic [port_g_width-1:0] next_port_g_out;
   logic [port_g_width-1:0] next_port_g_oe;
   logic [timer_pins-1:0] next_capture_compare_pins;

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   pin_sync #(.width(port_e_width)) u_sync_e
   (
      .sys_clk(sys_clk),
      .async_in(port_e_in),
      .sync_out(e_sync)
   );

   pin_sync #(.width(port_f_width)) u_sync_f
   (
      .sys_clk(sys_clk),
      .async_in(port_f_in),
      .sync_out(f_sync)
   );

   pin_sync #(.width(port_g_width)) u_sync_g
   (
      .sys_clk(sys_clk),
      .async_in(port_g_in),
      .sync_out(g_sync)
   );

   // timer channel n owns port f pin n when its edge/level field is nonzero
   genvar i;
   generate
      for (i = 0; i < port_f_width; i = i + 1)
      begin : g_f_owner
         if (i < timer_pins)
         begin : g_timer
            assign f_owns[i] = (edge_level_select[2*i+1:2*i] != els_gpio);
            assign f_pout[i] = capture_compare_out[i];
            assign f_poe[i] = capture_compare_oe[i];
         end
         else
         begin : g_plain
            assign f_owns[i] = 1'b0;
            assign f_pout[i] = 1'b0;
            assign f_poe[i] = 1'b0;
         end
      end

      for (i = 0; i < port_e_width; i = i + 1)
      begin : g_e_bit
         port_bit u_bit
         (
            .latch(port_e_latches[i]),
            .dir(port_e_direction[i]),
            .pin_level(e_sync[i]),
            .periph_owns(port_e_periph_owns[i]),
            .periph_out(port_e_periph_out[i]),
            .periph_oe(port_e_periph_oe[i]),
            .read_value(e_read[i]),
            .drive_value(e_val[i]),
            .drive_oe(e_en[i])
         );
      end

      for (i = 0; i < port_f_width; i = i + 1)
      begin : g_f_bit
         port_bit u_bit
         (
            .latch(port_f_pin_data[i]),
            .dir(port_f_direction[i]),
            .pin_level(f_sync[i]),
            .periph_owns(f_owns[i]),
            .periph_out(f_pout[i]),
            .periph_oe(f_poe[i]),
            .read_value(f_read[i]),
            .drive_value(f_val[i]),
            .drive_oe(f_en[i])
         );
      end

      for (i = 0; i < port_g_width; i = i + 1)
      begin : g_g_bit
         port_bit u_bit
         (
            .latch(port_g_pin_data[i]),
            .dir(port_g_direction[i]),
            .pin_level(g_sync[i]),
            .periph_owns(1'b0),
            .periph_out(1'b0),
            .periph_oe(1'b0),
            .read_value(g_read[i]),
            .drive_value(g_val[i]),
            .drive_oe(g_en[i])
         );
      end
   endgenerate

   // register writes and read mux
   always_comb
   begin
      next_port_e_latches = port_e_latches;
      next_port_e_direction = port_e_direction;
      next_port_f_pin_data = port_f_pin_data;
      next_port_f_direction = port_f_direction;
      next_port_g_pin_data = port_g_pin_data;
      next_port_g_direction = port_g_direction;
      next_rdata = 8'h00;
      if (req.wr)
      begin
         case (req.addr)
            port_e_data_offset: next_port_e_latches = req.wdata;
            port_f_data_offset: next_port_f_pin_data = req.wdata[port_f_width-1:0];
            port_g_data_offset: next_port_g_pin_data = req.wdata[port_g_width-1:0];
            port_e_dir_offset: next_port_e_direction = req.wdata;
            port_f_dir_offset: next_port_f_direction = req.wdata[port_f_width-1:0];
            port_g_dir_offset: next_port_g_direction = req.wdata[port_g_width-1:0];
            default: ;
         endcase
      end
      if (req.rd)
      begin
         case (req.addr)
            port_e_data_offset: next_rdata = e_read;
            port_f_data_offset: next_rdata = {3'h0, f_read};
            port_g_data_offset: next_rdata = {5'h00, g_read};
            port_e_dir_offset: next_rdata = port_e_direction;
            port_f_dir_offset: next_rdata = {3'h0, port_f_direction};
            port_g_dir_offset: next_rdata = {5'h00, port_g_direction};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // data latches deliberately have no reset so values survive it
   always_ff @(posedge sys_clk)
   begin
      port_e_latches <= next_port_e_latches;
      port_f_pin_data <= next_port_f_pin_data;
      port_g_pin_data <= next_port_g_pin_data;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         port_e_direction <= dir_reset_value[port_e_width-1:0];
         port_f_direction <= dir_reset_value[port_f_width-1:0];
         port_g_direction <= dir_reset_value[port_g_width-1:0];
         rdata <= 8'h00;
      end
      else
      begin
         port_e_direction <= next_port_e_direction;
         port_f_direction <= next_port_f_direction;
         port_g_direction <= next_port_g_direction;
         rdata <= next_rdata;
      end
   end

   // pin drive registered so outputs come from flops; adds one cycle of latency
   always_comb
   begin
      next_e_drive.value = e_val;
      next_e_drive.oe = e_en;
      next_port_f_out = f_val;
      next_port_f_oe = f_en;
      next_port_g_out = g_val;
      next_port_g_oe = g_en;
      next_capture_compare_pins = f_sync[timer_pins-1:0];
   end

   // oe and value cleared in reset; value then follows the unreset latch and may be unknown, harmless while floating
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         e_drive <= '0;
         port_f_out <= '0;
         port_f_oe <= '0;
         port_g_out <= '0;
         port_g_oe <= '0;
         capture_compare_pins <= '0;
      end
      else
      begin
         e_drive <= next_e_drive;
         port_f_out <= next_port_f_out;
         port_f_oe <= next_port_f_oe;
         port_g_out <= next_port_g_out;
         port_g_oe <= next_port_g_oe;
         capture_compare_pins <= next_capture_compare_pins;
      end
   end

   assign port_e_out = e_drive.value;
   assign port_e_oe = e_drive.oe;
endmodule : gpio_ports_e_f_g

//--- verification/pin_board.sv
// board model of the wires on one port
`timescale 1ns/1ps
module pin_board #(parameter int width = 8)
(
   input wire logic [width-1:0] out,
   input wire logic [width-1:0] oe,
   input wire logic [width-1:0] ext,
   output logic [width-1:0] level
);
   // floating bits see the outside source, which never goes idle
   assign level = (out & oe) | (ext & ~oe);
endmodule : pin_board

//--- verification/gpio_efg_sva.sv
// assertions on the port e/f/g block ports
`timescale 1ns/1ps
module gpio_efg_sva
   import gpio_efg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic [port_e_width-1:0] port_e_oe,
   input wire logic [port_f_width-1:0] port_f_out,
   input wire logic [port_f_width-1:0] port_f_oe,
   input wire logic [2*timer_pins-1:0] edge_level_select,
   input wire logic [timer_pins-1:0] capture_compare_out,
   input wire logic [timer_pins-1:0] capture_compare_oe,
   input wire logic [port_g_width-1:0] port_g_out,
   input wire logic [port_g_width-1:0] port_g_oe
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   property p_g_rsvd; rd && addr == 8'h0e |=> rdata[7:3] == 5'h00; endproperty
   a_g_rsvd: assert property (p_g_rsvd) else $error("g direction upper bits set");
   property p_f_up; rd && (addr == 8'h09 || addr == 8'h0d) |=> rdata[7:5] == 3'h0; endproperty
   a_f_up: assert property (p_f_up) else $error("f upper bits set");
   property p_g_oe; logic [7:0] v; (wr && addr == 8'h0e, v = wdata) |-> ##2 port_g_oe == v[2:0]; endproperty
   a_g_oe: assert property (p_g_oe) else $error("g enable wrong");
   property p_f_oe; logic [7:0] v; (wr && addr == 8'h0d, v = wdata) |-> ##2 port_f_oe[4] == v[4]; endproperty
   a_f_oe: assert property (p_f_oe) else $error("f pin 4 enable wrong");
   property p_rst; disable iff (1'b0) !resetn |=> port_e_oe == 8'h00 && port_f_oe == 5'h00 && port_g_oe == 3'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("enable not cleared by reset");
   property p_tmr_oe; edge_level_select[1:0] != 2'h0 |=> port_f_oe[0] == $past(capture_compare_oe[0]); endproperty
   a_tmr_oe: assert property (p_tmr_oe) else $error("timer enable not used");
   property p_tmr_out; edge_level_select[7:6] != 2'h0 |=> port_f_out[3] == $past(capture_compare_out[3]); endproperty
   a_tmr_out: assert property (p_tmr_out) else $error("timer drive not used");
   property p_g_out;
      logic [7:0] v;
      (wr && addr == 8'h0a, v = wdata) |-> ##2 (port_g_out & port_g_oe) == (v[2:0] & port_g_oe);
   endproperty
   a_g_out: assert property (p_g_out) else $error("g drive value wrong");
   c_tmr: cover property (edge_level_select != 8'h00 && capture_compare_oe != 4'h0);
   c_gdir: cover property (wr && addr == 8'h0e);
   c_frd: cover property (rd && addr == 8'h09);
endmodule : gpio_efg_sva

//--- verification/tb_gpio_ports_e_f_g.sv
// self-checking bench for the port e/f/g block
`timescale 1ns/1ps
module tb_gpio_ports_e_f_g;
   import gpio_efg_pkg::*;
   logic sys_clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, els = 8'h00;
   logic [7:0] e_in, e_out, e_oe, e_own = 8'h00, e_zero = 8'h00, e_ext = 8'h96;
   logic [4:0] f_in, f_out, f_oe, f_ext = 5'h16;
   logic [3:0] cc_out = 4'h0, cc_oe = 4'h0, cc_pins;
   logic [2:0] g_in, g_out, g_oe, g_ext = 3'h6;
   int miscompares = 0, n_checks = 0;
   gpio_ports_e_f_g u_gpio_ports_e_f_g (.sys_clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .port_e_in(e_in),
      .port_e_out(e_out), .port_e_oe(e_oe), .port_e_periph_owns(e_own), .port_e_periph_out(e_zero),
      .port_e_periph_oe(e_zero), .port_f_in(f_in), .port_f_out(f_out), .port_f_oe(f_oe), .edge_level_select(els),
      .capture_compare_out(cc_out), .capture_compare_oe(cc_oe), .capture_compare_pins(cc_pins), .port_g_in(g_in),
      .port_g_out(g_out), .port_g_oe(g_oe));
   pin_board #(.width(8)) u_pin_board_e (.out(e_out), .oe(e_oe), .ext(e_ext), .level(e_in));
   pin_board #(.width(5)) u_pin_board_f (.out(f_out), .oe(f_oe), .ext(f_ext), .level(f_in));
   pin_board #(.width(3)) u_pin_board_g (.out(g_out), .oe(g_oe), .ext(g_ext), .level(g_in));
   initial
   begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // strobes are lowered by whoever comes next, so back-to-back calls never assign one signal twice in a step
   task automatic idle(input int n);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge sys_clk);
   endtask : idle
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      wr <= 1'b1;
      rd <= 1'b0;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk);
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      rd <= 1'b1;
      wr <= 1'b0;
      addr <= a;
      @(posedge sys_clk);
      #1 chk({8'h00, rdata}, {8'h00, exp});
   endtask : rd_reg
   task automatic t_reset;
      resetn <= 1'b0;
      idle(3);
      resetn <= 1'b1;
      idle(1);
      rd_reg(8'h0d, dir_reset_value);
      rd_reg(8'h0e, dir_reset_value);
      chk({e_oe, f_oe, g_oe}, 16'h0000);
   endtask : t_reset
   task automatic t_port(input logic [7:0] d, input logic [7:0] m, input logic [15:0] eo);
      wr_reg(d, 8'h3c);
      idle(5);
      rd_reg(d, 8'h96 & m);
      wr_reg(d + 8'h04, 8'h0f);
      idle(5);
      wr_reg(d, 8'h55);
      rd_reg(d, 8'h95 & m);
      idle(5);
      chk({e_oe, f_oe, g_oe}, eo);
      chk({e_out, f_out, g_out} & {e_oe, f_oe, g_oe}, 16'h55ad & eo);
   endtask : t_port
   task automatic t_timer;
      els <= 8'h41;
      cc_oe <= 4'h1;
      wr_reg(8'h0d, 8'h00);
      idle(5);
      chk(16'(f_oe), 16'h0001);
      chk(16'(cc_pins), 16'h0006);
      rd_reg(8'h09, 8'h16);
      wr_reg(8'h0d, 8'h1f);
      idle(5);
      chk(16'(f_oe), 16'h0017);
      rd_reg(8'h09, 8'h15);
      els <= 8'h00;
   endtask : t_timer
   task automatic t_periph;
      e_own <= 8'hf0;
      wr_reg(8'h0c, 8'hff);
      idle(5);
      chk(16'(e_oe), 16'h000f);
      rd_reg(8'h08, 8'h55);
      wr_reg(8'h0c, 8'h00);
      idle(5);
      rd_reg(8'h08, 8'h96);
      e_own <= 8'h00;
   endtask : t_periph
   task automatic t_latch_hold;
      t_reset;
      wr_reg(8'h0d, 8'h1f);
      wr_reg(8'h0e, 8'h07);
      rd_reg(8'h09, 8'h15);
      rd_reg(8'h0a, 8'h05);
   endtask : t_latch_hold
   task automatic t_upper;
      wr_reg(8'h0d, 8'hff);
      rd_reg(8'h0d, 8'h1f);
      wr_reg(8'h0e, 8'hff);
      rd_reg(8'h0e, 8'h07);
      wr_reg(8'h0f, 8'hff);
      rd_reg(8'h0f, 8'h00);
      rd_reg(8'h0b, 8'h00);
   endtask : t_upper
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test
   initial
   begin
      t_reset;
      t_port(8'h08, 8'hff, 16'h0f00);
      t_port(8'h09, 8'h1f, 16'h0f78);
      t_port(8'h0a, 8'h07, 16'h0f7f);
      t_timer;
      t_periph;
      t_latch_hold;
      t_upper;
      finish_test;
   end
   initial
   begin
      // the whole sequence needs about 110 cycles
      #50000;
      miscompares++;
      finish_test;
   end
endmodule : tb_gpio_ports_e_f_g
bind gpio_ports_e_f_g gpio_efg_sva u_gpio_efg_sva (.sys_clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .port_e_oe,
   .port_f_out, .port_f_oe, .edge_level_select, .capture_compare_out, .capture_compare_oe, .port_g_out, .port_g_oe);
